/* core/nvmac_params.svh */
// Constants for the nonvolatile memory access control block.
// Assumes a 9-bit special function register address and a 50 MHz core clock.
`ifndef NVMAC_PARAMS_SVH
`define NVMAC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define NVMAC_OFF_DATA_LOW   9'h10C
`define NVMAC_OFF_ADDR_LOW   9'h10D
`define NVMAC_OFF_DATA_HIGH  9'h10E
`define NVMAC_OFF_ADDR_HIGH  9'h10F
`define NVMAC_OFF_CTRL       9'h18C
`define NVMAC_OFF_KEY        9'h18D
`define NVMAC_OFF_FLAG_ONE   9'h00C

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define NVMAC_CTRL_RD        0
`define NVMAC_CTRL_WR        1
`define NVMAC_CTRL_PERMIT    2
`define NVMAC_CTRL_ABORT     3
`define NVMAC_CTRL_SPACE     7
`define NVMAC_FLAG_DONE      7
`define NVMAC_CTRL_RESET     8'h00
`define NVMAC_KEY_FIRST      8'h3C
`define NVMAC_KEY_SECOND     8'hC3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define NVMAC_CLK_MHZ        50
`define NVMAC_ERASE_TIME_US  2000
`define NVMAC_PROG_TIME_US   2000
`define NVMAC_TMR_W          24
`define NVMAC_PF_WORDS       8192

`endif

/* core/nvmac_pkg.sv */
// Types for the nonvolatile memory access control block.
// Assumes nvmac_params.svh is on the include path.
`include "nvmac_params.svh"

package nvmac_pkg;

    // ------------------------------------------------------------------
    // Register select and timer phase
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        NVMAC_REG_NONE,
        NVMAC_REG_DATA_LOW,
        NVMAC_REG_DATA_HIGH,
        NVMAC_REG_ADDR_LOW,
        NVMAC_REG_ADDR_HIGH,
        NVMAC_REG_CTRL,
        NVMAC_REG_KEY,
        NVMAC_REG_FLAG_ONE
    } nvmac_reg_t;

    typedef enum logic [1:0] {
        NVMAC_PH_IDLE,
        NVMAC_PH_ERASE,
        NVMAC_PH_PROG
    } nvmac_phase_t;

    // ------------------------------------------------------------------
    // State records
    // ------------------------------------------------------------------
    typedef struct packed {
        nvmac_phase_t                phase;
        logic [`NVMAC_TMR_W-1:0]     cnt;
        logic                        erase_en;
        logic                        prog_en;
        logic                        done;
    } nvmac_tmr_t;

    typedef struct packed {
        logic        space;
        logic        permit;
        logic        abort;
        logic        rd;
        logic        wr;
        logic        done_flag;
        logic [1:0]  key_stage;
        logic        first;
        logic        ee_rd;
        logic        pf_rd;
        logic        cap;
        logic        cap_pf;
        logic        cap_pgm;
        logic        tmr_start;
        logic [12:0] arr_addr;
        logic [7:0]  wdata;
        logic [7:0]  rdata;
        logic [2:0]  sync_cp;
        logic [2:0]  sync_req;
        logic        cp;
        logic        req;
        logic        req_q;
        logic        pgm_pend;
        logic [13:0] pgm_rdata;
        logic        pgm_valid;
        logic        pgm_denied;
    } nvmac_ctrl_t;

    // Survives warm resets so an interrupted write can be retried
    typedef struct packed {
        logic [7:0] data_low;
        logic [5:0] data_high;
        logic [7:0] addr_low;
        logic [4:0] addr_high;
        logic       in_flight;
    } nvmac_keep_t;

endpackage

/* core/nvmac_write_timer.sv */
// Self-timed erase-then-program sequencer for one data byte write.
// Assumes start is a one-cycle pulse given only while the sequencer is idle.
`timescale 1ns/1ps
`include "nvmac_params.svh"

module nvmac_write_timer #(
    parameter int unsigned ERASE_CYC = 100000,
    parameter int unsigned PROG_CYC  = 100000
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Control
    input  wire logic start,
    // Array strobes
    output logic      erase_en,
    output logic      prog_en,
    output logic      done
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (ERASE_CYC == 0 || PROG_CYC == 0 ||
        ERASE_CYC > (1 << `NVMAC_TMR_W) || PROG_CYC > (1 << `NVMAC_TMR_W)) begin : g_bad
        $error("write timer counts out of range");
    end

    nvmac_pkg::nvmac_tmr_t st;
    nvmac_pkg::nvmac_tmr_t next_st;

    // Erase always precedes program; software has no way to skip it
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        case (st.phase)
            nvmac_pkg::NVMAC_PH_IDLE: begin
                if (start) begin
                    next_st.phase    = nvmac_pkg::NVMAC_PH_ERASE;
                    next_st.cnt      = `NVMAC_TMR_W'(ERASE_CYC - 1);
                    next_st.erase_en = 1'b1;
                end
            end
            nvmac_pkg::NVMAC_PH_ERASE: begin
                if (st.cnt == '0) begin
                    next_st.phase    = nvmac_pkg::NVMAC_PH_PROG;
                    next_st.cnt      = `NVMAC_TMR_W'(PROG_CYC - 1);
                    next_st.erase_en = 1'b0;
                    next_st.prog_en  = 1'b1;
                end else begin
                    next_st.cnt = st.cnt - 1'b1;
                end
            end
            nvmac_pkg::NVMAC_PH_PROG: begin
                if (st.cnt == '0) begin
                    next_st.phase   = nvmac_pkg::NVMAC_PH_IDLE;
                    next_st.prog_en = 1'b0;
                    next_st.done    = 1'b1;
                end else begin
                    next_st.cnt = st.cnt - 1'b1;
                end
            end
            default: next_st = '0;
        endcase
    end

    // State register; a reset mid-write drops the array strobes at once
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign erase_en = st.erase_en;
    assign prog_en  = st.prog_en;
    assign done     = st.done;

endmodule

/* core/nvmac_access_ctrl.sv */
// Register front end for the data EEPROM and program flash arrays.
// Assumes arrays answer a read strobe with data one clock later, and that
// the reset controller holds its cause levels stable across reset release.
`timescale 1ns/1ps
`include "nvmac_params.svh"

// What this block does
// - Data bytes use data-low and address-low registers, addresses 0h to 0FFh.
// - Program reads join data into 14 bits and address into 13 bits.
// - Program memory reads one word at a time, 4k or 8k words.
// - Each data byte write erases the location, then programs it.
// - An internal timer sets write duration; hardware signals completion.
// - Code protection blocks the external programmer, never the processor.
// - Space select resets to data; program space allows reads only.
// - Read and write start bits are set-only; hardware clears them.
// - Data writes need the write permit bit, cleared at power-up.
// - Pin or watchdog reset during a write sets abort, keeps data.
// - Write completion sets flag bit 7; software clears it.
// - Key register stores nothing, reads zero, serves the write sequence.
module nvmac_access_ctrl #(
    parameter int unsigned PF_WORDS  = `NVMAC_PF_WORDS,
    parameter int unsigned ERASE_CYC = `NVMAC_ERASE_TIME_US * `NVMAC_CLK_MHZ,
    parameter int unsigned PROG_CYC  = `NVMAC_PROG_TIME_US * `NVMAC_CLK_MHZ
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Reset cause from the reset controller
    input  wire logic        power_on_cause,
    input  wire logic        warm_reset_cause,
    // Special function register port
    input  wire logic [8:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    output logic             write_done_flag,
    // Data EEPROM array
    output logic      [7:0]  ee_addr,
    output logic      [7:0]  ee_wdata,
    output logic             ee_rd_en,
    output logic             ee_erase_en,
    output logic             ee_prog_en,
    input  wire logic [7:0]  ee_rdata,
    // Program flash array
    output logic      [12:0] pf_addr,
    output logic             pf_rd_en,
    input  wire logic [13:0] pf_rdata,
    // External programmer pins
    input  wire logic        code_protect,
    input  wire logic        pgm_req,
    input  wire logic        pgm_space,
    input  wire logic [12:0] pgm_addr,
    output logic      [13:0] pgm_rdata,
    output logic             pgm_valid,
    output logic             pgm_denied
);

    // ------------------------------------------------------------------
    // Elaboration checks and derived constants
    // ------------------------------------------------------------------
    if (PF_WORDS != 4096 && PF_WORDS != 8192) begin : g_bad
        $error("program memory must hold 4096 or 8192 words");
    end

    localparam logic [12:0] PF_MASK = 13'(PF_WORDS - 1);

    // Decode shared by the read and write paths
    function automatic nvmac_pkg::nvmac_reg_t reg_sel(input logic [8:0] a);
        case (a)
            `NVMAC_OFF_DATA_LOW:  reg_sel = nvmac_pkg::NVMAC_REG_DATA_LOW;
            `NVMAC_OFF_DATA_HIGH: reg_sel = nvmac_pkg::NVMAC_REG_DATA_HIGH;
            `NVMAC_OFF_ADDR_LOW:  reg_sel = nvmac_pkg::NVMAC_REG_ADDR_LOW;
            `NVMAC_OFF_ADDR_HIGH: reg_sel = nvmac_pkg::NVMAC_REG_ADDR_HIGH;
            `NVMAC_OFF_CTRL:      reg_sel = nvmac_pkg::NVMAC_REG_CTRL;
            `NVMAC_OFF_KEY:       reg_sel = nvmac_pkg::NVMAC_REG_KEY;
            `NVMAC_OFF_FLAG_ONE:  reg_sel = nvmac_pkg::NVMAC_REG_FLAG_ONE;
            default:              reg_sel = nvmac_pkg::NVMAC_REG_NONE;
        endcase
    endfunction

    nvmac_pkg::nvmac_ctrl_t st;
    nvmac_pkg::nvmac_ctrl_t next_st;
    nvmac_pkg::nvmac_keep_t keep;
    nvmac_pkg::nvmac_keep_t next_keep;
    logic                   tmr_done;
    logic                   busy;
    logic [7:0]             ctrl_view;

    // ------------------------------------------------------------------
    // Write sequencer
    // ------------------------------------------------------------------
    nvmac_write_timer #(
        .ERASE_CYC (ERASE_CYC),
        .PROG_CYC  (PROG_CYC)
    ) u_timer (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .start     (st.tmr_start),
        .erase_en  (ee_erase_en),
        .prog_en   (ee_prog_en),
        .done      (tmr_done)
    );

    // One operation at a time; software starts given while this is high are ignored
    assign busy = st.wr | st.rd | st.ee_rd | st.pf_rd | st.cap;

    // Control register as software sees it
    always_comb begin
        ctrl_view                       = 8'h00;
        ctrl_view[`NVMAC_CTRL_RD]       = st.rd;
        ctrl_view[`NVMAC_CTRL_WR]       = st.wr;
        ctrl_view[`NVMAC_CTRL_PERMIT]   = st.permit;
        ctrl_view[`NVMAC_CTRL_ABORT]    = st.abort;
        ctrl_view[`NVMAC_CTRL_SPACE]    = st.space;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st           = st;
        next_keep         = keep;
        next_st.tmr_start = 1'b0;
        next_st.pgm_valid = 1'b0;
        next_st.first     = 1'b0;
        next_st.req_q     = st.req;

        // Pin synchronisers: a change counts once stages two and three agree
        next_st.sync_cp  = {st.sync_cp[1:0], code_protect};
        next_st.sync_req = {st.sync_req[1:0], pgm_req};
        if (st.sync_cp[1] == st.sync_cp[2]) begin
            next_st.cp = st.sync_cp[2];
        end
        if (st.sync_req[1] == st.sync_req[2]) begin
            next_st.req = st.sync_req[2];
        end
        next_st.pgm_denied = st.cp;
        if (st.req && !st.req_q) begin
            next_st.pgm_pend = 1'b1;
        end

        // Register reads; key register has no storage behind it
        if (sfr_rd) begin
            case (reg_sel(sfr_addr))
                nvmac_pkg::NVMAC_REG_DATA_LOW:  next_st.rdata = keep.data_low;
                nvmac_pkg::NVMAC_REG_DATA_HIGH: next_st.rdata = {2'h0, keep.data_high};
                nvmac_pkg::NVMAC_REG_ADDR_LOW:  next_st.rdata = keep.addr_low;
                nvmac_pkg::NVMAC_REG_ADDR_HIGH: next_st.rdata = {3'h0, keep.addr_high};
                nvmac_pkg::NVMAC_REG_CTRL:      next_st.rdata = ctrl_view;
                nvmac_pkg::NVMAC_REG_FLAG_ONE:  next_st.rdata = {st.done_flag, 7'h00};
                default:                        next_st.rdata = 8'h00;
            endcase
        end

        // Register writes; any write other than the second key breaks the unlock
        if (sfr_wr) begin
            next_st.key_stage = 2'd0;
            case (reg_sel(sfr_addr))
                nvmac_pkg::NVMAC_REG_DATA_LOW:
                    if (!busy) next_keep.data_low = sfr_wdata;
                nvmac_pkg::NVMAC_REG_DATA_HIGH:
                    if (!busy) next_keep.data_high = sfr_wdata[5:0];
                nvmac_pkg::NVMAC_REG_ADDR_LOW:
                    if (!busy) next_keep.addr_low = sfr_wdata;
                nvmac_pkg::NVMAC_REG_ADDR_HIGH:
                    if (!busy) next_keep.addr_high = sfr_wdata[4:0];
                nvmac_pkg::NVMAC_REG_KEY: begin
                    if (sfr_wdata == `NVMAC_KEY_FIRST) begin
                        next_st.key_stage = 2'd1;
                    end else if (st.key_stage == 2'd1 && sfr_wdata == `NVMAC_KEY_SECOND) begin
                        next_st.key_stage = 2'd2;
                    end
                end
                nvmac_pkg::NVMAC_REG_CTRL: begin
                    next_st.permit = sfr_wdata[`NVMAC_CTRL_PERMIT];
                    next_st.abort  = sfr_wdata[`NVMAC_CTRL_ABORT];
                    if (!busy) begin
                        next_st.space = sfr_wdata[`NVMAC_CTRL_SPACE];
                        if (sfr_wdata[`NVMAC_CTRL_RD]) begin
                            next_st.rd    = 1'b1;
                            next_st.ee_rd = !sfr_wdata[`NVMAC_CTRL_SPACE];
                            next_st.pf_rd = sfr_wdata[`NVMAC_CTRL_SPACE];
                            next_st.arr_addr = sfr_wdata[`NVMAC_CTRL_SPACE] ?
                                {keep.addr_high, keep.addr_low} & PF_MASK :
                                {5'h00, keep.addr_low};
                        end else if (sfr_wdata[`NVMAC_CTRL_WR] && st.permit &&
                                     st.key_stage == 2'd2 &&
                                     !sfr_wdata[`NVMAC_CTRL_SPACE]) begin
                            next_st.wr        = 1'b1;
                            next_st.tmr_start = 1'b1;
                            next_st.arr_addr  = {5'h00, keep.addr_low};
                            next_st.wdata     = keep.data_low;
                            next_keep.in_flight = 1'b1;
                        end
                    end
                end
                nvmac_pkg::NVMAC_REG_FLAG_ONE:
                    next_st.done_flag = sfr_wdata[`NVMAC_FLAG_DONE];
                default: ;
            endcase
        end

        // Programmer read, served only when the processor is idle
        if (st.pgm_pend && !busy && !sfr_wr) begin
            next_st.pgm_pend = 1'b0;
            if (!st.cp) begin
                next_st.cap_pgm  = 1'b1;
                next_st.ee_rd    = !pgm_space;
                next_st.pf_rd    = pgm_space;
                next_st.arr_addr = pgm_space ? (pgm_addr & PF_MASK) : {5'h00, pgm_addr[7:0]};
            end
        end

        // Read pipeline: strobe, then capture one clock later
        if (st.ee_rd || st.pf_rd) begin
            next_st.ee_rd  = 1'b0;
            next_st.pf_rd  = 1'b0;
            next_st.cap    = 1'b1;
            next_st.cap_pf = st.pf_rd;
        end
        if (st.cap) begin
            next_st.cap = 1'b0;
            if (st.cap_pgm) begin
                next_st.cap_pgm   = 1'b0;
                next_st.pgm_valid = 1'b1;
                next_st.pgm_rdata = st.cap_pf ? pf_rdata : {6'h00, ee_rdata};
            end else begin
                next_st.rd = 1'b0;
                if (st.cap_pf) begin
                    next_keep.data_low  = pf_rdata[7:0];
                    next_keep.data_high = pf_rdata[13:8];
                end else begin
                    next_keep.data_low = ee_rdata;
                end
            end
        end

        // Completion sets the flag even against a software clear
        if (tmr_done) begin
            next_st.wr          = 1'b0;
            next_st.done_flag   = 1'b1;
            next_keep.in_flight = 1'b0;
        end

        // First clock after release: judge an interrupted write
        if (st.first) begin
            if (warm_reset_cause && !power_on_cause && keep.in_flight) begin
                next_st.abort = 1'b1;
            end
            next_keep.in_flight = 1'b0;
            if (power_on_cause) begin
                next_keep = '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    // Control state clears on every reset, except first, which reset sets to one
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st       <= '0;
            st.first <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // No reset here on purpose: data and address must outlive a warm reset
    always_ff @(posedge sys_clk) begin
        if (rst_n) begin
            keep <= next_keep;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------
    assign sfr_rdata       = st.rdata;
    assign write_done_flag = st.done_flag;
    assign ee_addr         = st.arr_addr[7:0];
    assign ee_wdata        = st.wdata;
    assign ee_rd_en        = st.ee_rd;
    assign pf_addr         = st.arr_addr;
    assign pf_rd_en        = st.pf_rd;
    assign pgm_rdata       = st.pgm_rdata;
    assign pgm_valid       = st.pgm_valid;
    assign pgm_denied      = st.pgm_denied;

endmodule

/* dv/nvmac_chk.sv */
// Port checker for the nonvolatile access control block.
// Assumes the shared header is on the include path; bound below.
`timescale 1ns/1ps
`include "nvmac_params.svh"
module nvmac_chk #(
    parameter int unsigned PF_WORDS  = 8192,
    parameter int unsigned ERASE_CYC = 4,
    parameter int unsigned PROG_CYC  = 4
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // Register port
    input wire logic [8:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        write_done_flag,
    // Array strobes
    input wire logic        ee_rd_en,
    input wire logic        ee_erase_en,
    input wire logic        ee_prog_en,
    input wire logic        pf_rd_en,
    input wire logic [12:0] pf_addr,
    // Programmer port
    input wire logic        pgm_valid,
    input wire logic        pgm_denied
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    logic [23:0] ecnt;
    logic [23:0] pcnt;
    // Phase lengths, counted since a repetition would not scale
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ecnt <= 24'h000000;
            pcnt <= 24'h000000;
        end else begin
            ecnt <= ee_erase_en ? ecnt + 24'h000001 : 24'h000000;
            pcnt <= ee_prog_en ? pcnt + 24'h000001 : 24'h000000;
        end
    end
    sequence s_done;
        ##[0:1] write_done_flag;
    endsequence
    a_erase_then_prog: assert property ($fell(ee_erase_en) |-> ecnt == 24'(ERASE_CYC) && ee_prog_en)
        else $error("erase phase wrong");
    a_prog_then_done: assert property ($fell(ee_prog_en) |-> pcnt == 24'(PROG_CYC) ##0 s_done)
        else $error("program phase wrong");
    a_erase_cause: assert property ($rose(ee_erase_en) |-> $past(sfr_wr, 2) && $past(sfr_addr, 2) == `NVMAC_OFF_CTRL)
        else $error("erase without control write");
    a_phase_apart: assert property (!(ee_erase_en && ee_prog_en))
        else $error("erase and program overlap");
    a_key_reads_zero: assert property (sfr_rd && sfr_addr == `NVMAC_OFF_KEY |=> sfr_rdata == 8'h00)
        else $error("key register read not zero");
    a_flag_read: assert property (sfr_rd && sfr_addr == `NVMAC_OFF_FLAG_ONE |=> sfr_rdata == {$past(write_done_flag), 7'h00})
        else $error("flag register read wrong");
    a_rd_one_pulse: assert property (ee_rd_en || pf_rd_en |=> !ee_rd_en && !pf_rd_en)
        else $error("read strobe too long");
    a_pf_in_range: assert property (pf_rd_en |-> 32'(pf_addr) < PF_WORDS)
        else $error("flash address out of range");
    a_pgm_blocked: assert property (pgm_denied |-> !pgm_valid)
        else $error("programmer served while protected");
endmodule
bind nvmac_access_ctrl nvmac_chk #(.PF_WORDS(PF_WORDS), .ERASE_CYC(ERASE_CYC), .PROG_CYC(PROG_CYC))
    nvmac_chk_i (.*);

/* dv/nvmac_mem_model.sv */
// Behavioural data EEPROM and program flash arrays.
// Assumes strobes are registered outputs of the access block.
`timescale 1ns/1ps
module nvmac_mem_model (
    // Clock
    input wire logic        sys_clk,
    // Data array
    input wire logic [7:0]  ee_addr,
    input wire logic [7:0]  ee_wdata,
    input wire logic        ee_rd_en,
    input wire logic        ee_erase_en,
    input wire logic        ee_prog_en,
    output logic     [7:0]  ee_rdata,
    // Flash array
    input wire logic [12:0] pf_addr,
    input wire logic        pf_rd_en,
    output logic     [13:0] pf_rdata
);
    // Known contents so reads can be predicted
    logic [7:0]  ee [256] = '{default: 8'h00};
    logic [13:0] pf [8192];
    initial begin
        for (int i = 0; i < 8192; i++) pf[i] = 14'(i) ^ 14'h2A5A;
    end
    // Erase to ones, then program; outputs scramble when not read
    always_ff @(posedge sys_clk) begin
        if (ee_erase_en) ee[ee_addr] <= 8'hFF;
        if (ee_prog_en) ee[ee_addr] <= ee_wdata;
        ee_rdata <= ee_rd_en ? ee[ee_addr] : ~ee_rdata;
        pf_rdata <= pf_rd_en ? pf[pf_addr] : ~pf_rdata;
    end
endmodule

/* dv/tb_top.sv */
// Self-checking bench for the access control block.
// Assumes the memory model and checker files are compiled first.
`timescale 1ns/1ps
`include "nvmac_params.svh"
module tb_top;
    localparam logic [8:0] DL = `NVMAC_OFF_DATA_LOW, AL = `NVMAC_OFF_ADDR_LOW;
    localparam logic [8:0] DH = `NVMAC_OFF_DATA_HIGH, AH = `NVMAC_OFF_ADDR_HIGH;
    localparam logic [8:0] CT = `NVMAC_OFF_CTRL, KY = `NVMAC_OFF_KEY, FL = `NVMAC_OFF_FLAG_ONE;
    logic        sys_clk, rst_n, power_on_cause, warm_reset_cause, sfr_wr, sfr_rd;
    logic [8:0]  sfr_addr;
    logic [7:0]  sfr_wdata, sfr_rdata, ee_addr, ee_wdata, ee_rdata, v;
    logic        write_done_flag, ee_rd_en, ee_erase_en, ee_prog_en, pf_rd_en;
    logic [12:0] pf_addr, pgm_addr;
    logic [13:0] pf_rdata, pgm_rdata;
    logic        code_protect, pgm_req, pgm_space, pgm_valid, pgm_denied, seen_v;
    int          n_errors, num_checks;
    nvmac_access_ctrl #(.PF_WORDS(8192), .ERASE_CYC(4), .PROG_CYC(4)) nvmac_access_ctrl_i (.*);
    nvmac_mem_model nvmac_mem_model_i (.*);
    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Catches a programmer answer that should never come
    always @(posedge sys_clk) seen_v <= rst_n & (seen_v | pgm_valid);
    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, seen);
            n_errors++;
        end
    endtask
    task conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Inputs move only at the falling edge
    task wr(input logic [8:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
    endtask
    task rd(input logic [8:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge sys_clk);
        sfr_rd = 1'b0;
        @(negedge sys_clk);
        d = sfr_rdata;
    endtask
    task rchk(input string nm, input logic [8:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        chk(nm, {8'h00, d}, {8'h00, e});
    endtask
    // Key pair then the control byte, with nothing between
    task wsq(input logic [7:0] c);
        wr(KY, 8'h3C);
        wr(KY, 8'hC3);
        wr(CT, c);
    endtask
    task automatic waitfor(ref logic s, input int n);
        for (int i = 0; i < n && s !== 1'b1; i++) @(negedge sys_clk);
        chk("wait", {15'h0000, s}, 16'h0001);
        if (s !== 1'b1) conclude();
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_n, warm_reset_cause, sfr_wr, sfr_rd, code_protect, pgm_req, pgm_space} = 7'h00;
        {sfr_addr, sfr_wdata, pgm_addr} = 30'h00000000;
        {power_on_cause, n_errors, num_checks} = {1'b1, 64'h0};
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        power_on_cause = 1'b0;
        rchk("ctrl", CT, 8'h00);
        rchk("key", KY, 8'h00);
        rchk("flag", FL, 8'h00);
        rchk("unmapped", 9'h1FF, 8'h00);
        wr(DL, 8'h5A);
        wr(AL, 8'h37);
        wsq(8'h02);
        rchk("no permit", CT, 8'h00);
        wr(CT, 8'h04);
        wr(CT, 8'h06);
        rchk("no key", CT, 8'h04);
        wsq(8'h06);
        rchk("busy", CT, 8'h06);
        wr(CT, 8'h04);
        rchk("no clear", CT, 8'h06);
        waitfor(write_done_flag, 50);
        rchk("done ctrl", CT, 8'h04);
        rchk("done flag", FL, 8'h80);
        chk("array", {8'h00, nvmac_mem_model_i.ee[8'h37]}, 16'h005A);
        wr(FL, 8'h00);
        rchk("flag clr", FL, 8'h00);
        // Protected: processor still reads, programmer is refused
        code_protect = 1'b1;
        wr(DL, 8'h00);
        pgm_space = 1'b1;
        pgm_addr = 13'h0005;
        pgm_req = 1'b1;
        wr(CT, 8'h05);
        @(negedge sys_clk);
        rchk("read back", DL, 8'h5A);
        rchk("rd clear", CT, 8'h04);
        chk("denied", {15'h0000, pgm_denied}, 16'h0001);
        chk("no answer", {15'h0000, seen_v}, 16'h0000);
        pgm_req = 1'b0;
        wr(AH, 8'h1F);
        wr(AL, 8'hFF);
        wr(CT, 8'h85);
        @(negedge sys_clk);
        rchk("word low", DL, 8'hA5);
        rchk("word high", DH, 8'h35);
        wsq(8'h86);
        rchk("pgm no write", CT, 8'h84);
        code_protect = 1'b0;
        repeat (5) @(negedge sys_clk);
        pgm_req = 1'b1;
        waitfor(pgm_valid, 20);
        chk("pgm word", {2'b00, pgm_rdata}, 16'h2A5F);
        pgm_req = 1'b0;
        // Warm reset in mid-write keeps data and flags the abort
        wr(CT, 8'h04);
        wr(DL, 8'h5A);
        wr(AL, 8'h37);
        wsq(8'h06);
        repeat (3) @(negedge sys_clk);
        {rst_n, warm_reset_cause} = 2'b01;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        warm_reset_cause = 1'b0;
        rd(CT, v);
        chk("abort", {15'h0000, v[3]}, 16'h0001);
        rchk("kept data", DL, 8'h5A);
        rchk("kept addr", AL, 8'h37);
        conclude();
    end
endmodule
